// file: liion_charge_phase_controller.sv
// Top of the lithium-ion charge phase sequencer with register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module liion_charge_phase_controller #(
   parameter int unsigned MS_CYCLES = charge_pkg::MS_CYCLES,
   parameter int unsigned BLINK_CYCLES = charge_pkg::BLINK_CYCLES,
   parameter int unsigned FAST_N = charge_pkg::AVG_FAST_N,
   parameter int unsigned SLOW_N = charge_pkg::AVG_SLOW_N
) (
   input wire logic sys_clk,              // 20 MHz clock
   input wire logic rst,                  // Async reset, high
   input wire logic [7:0] reg_addr,       // Register address
   input wire logic [7:0] reg_wdata,      // Write data
   input wire logic reg_wr,               // Write strobe
   input wire logic reg_rd,               // Read strobe
   output logic [7:0] reg_rdata,          // Read data, next cycle
   input wire logic wall_supply,          // Wall input valid pin
   input wire logic usb_supply,           // USB input valid pin
   input wire logic sys_on_charger,       // System fed from charger pin
   input wire logic app_power_good,       // Application powered pin
   input wire logic [12:0] bat_mv,        // Battery voltage, mV
   output logic conv_start,               // Current conversion request
   input wire logic conv_valid,           // Conversion result strobe
   input wire logic [11:0] conv_data,     // Charge current, mA
   output logic charge_en,                // Linear stage enable
   output logic precharge_active,         // Pre-charge current selected
   output logic cv_active,                // Constant-voltage regulation
   output logic [1:0] pre_charge_current, // Pre-charge current code
   output logic [5:0] fast_charge_current, // Fast-charge current code
   output logic [4:0] charge_target_voltage, // Target voltage code
   output logic wall_input_gate,          // Wall switch gate enable
   output logic usb_input_gate,           // USB switch gate enable
   output logic led_output_a,             // LED output a
   output logic led_output_b              // LED output b
);
   //-------------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------------
   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;
   logic wall_ok;
   logic usb_ok;
   logic on_chg;
   logic app_pg;
   logic chg_ok;

   // Two stages before any logic looks at the pins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_meta_q <= 4'h0;
         pin_sync_q <= 4'h0;
      end else begin
         pin_meta_q <= {app_power_good, sys_on_charger,
                        usb_supply, wall_supply};
         pin_sync_q <= pin_meta_q;
      end
   end

   assign wall_ok = pin_sync_q[0];
   assign usb_ok = pin_sync_q[1];
   assign on_chg = pin_sync_q[2];
   assign app_pg = pin_sync_q[3];
   assign chg_ok = wall_ok || usb_ok;

   //-------------------------------------------------------------------
   // Register file
   //-------------------------------------------------------------------
   logic [7:0] cur_cfg_q;
   logic [7:0] tgt_cfg_q;
   logic [7:0] rechg_cfg_q;
   logic [7:0] end_cur_q;
   logic [7:0] ctrl_q;
   logic eoc_flag_q;
   logic eoc_set;
   logic [7:0] rdata_q;
   charge_pkg::chg_state_e state_q;
   charge_pkg::chg_state_e state_d;

   // Writes to the programmed parameters
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cur_cfg_q <= charge_pkg::RST_CHG_CUR;
         tgt_cfg_q <= charge_pkg::RST_TGT_V;
         rechg_cfg_q <= charge_pkg::RST_RECHG;
         end_cur_q <= charge_pkg::RST_END_CUR;
         ctrl_q <= charge_pkg::RST_CTRL;
      end else if (reg_wr) begin
         case (reg_addr)
            charge_pkg::ADDR_CHG_CUR: cur_cfg_q <= reg_wdata;
            charge_pkg::ADDR_TGT_V: tgt_cfg_q <= reg_wdata;
            charge_pkg::ADDR_RECHG: rechg_cfg_q <= reg_wdata;
            charge_pkg::ADDR_END_CUR: end_cur_q <= reg_wdata;
            charge_pkg::ADDR_CTRL: ctrl_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Completion flag: a new completion outranks a clearing write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         eoc_flag_q <= 1'b0;
      end else if (eoc_set) begin
         eoc_flag_q <= 1'b1;
      end else if (reg_wr && reg_addr == charge_pkg::ADDR_STATUS
                   && reg_wdata[charge_pkg::STAT_EOC_BIT]) begin
         eoc_flag_q <= 1'b0;
      end
   end

   // Read data one cycle after the strobe, zero when unmapped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            charge_pkg::ADDR_CHG_CUR: rdata_q <= cur_cfg_q;
            charge_pkg::ADDR_TGT_V: rdata_q <= tgt_cfg_q;
            charge_pkg::ADDR_RECHG: rdata_q <= rechg_cfg_q;
            charge_pkg::ADDR_END_CUR: rdata_q <= end_cur_q;
            charge_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
            charge_pkg::ADDR_STATUS:
               rdata_q <= {2'b00, app_pg, chg_ok, eoc_flag_q, state_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

   //-------------------------------------------------------------------
   // Thresholds
   //-------------------------------------------------------------------
   logic [12:0] target_mv;
   logic [12:0] cv_mv;
   logic [12:0] recharge_mv;
   logic [12:0] drop_mv;

   // Target is a 25 mV ladder above 3.65 V
   assign target_mv = charge_pkg::VT_BASE_MV
      + 13'(tgt_cfg_q[charge_pkg::TGT_MSB:charge_pkg::TGT_LSB])
      * charge_pkg::VT_STEP_MV;
   assign cv_mv = target_mv - charge_pkg::CV_MARGIN_MV;
   assign drop_mv = rechg_cfg_q[charge_pkg::DROP_BIT]
      ? charge_pkg::DROP_HI_MV : charge_pkg::DROP_LO_MV;
   assign recharge_mv = target_mv - drop_mv;

   //-------------------------------------------------------------------
   // Current sampling and averaging
   //-------------------------------------------------------------------
   logic ms_tick;
   logic [3:0] slow_cnt_q;
   logic ten_ms;
   sample_if smp ();

   tick_divider #(.DIV(MS_CYCLES)) u_ms_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(ms_tick)
   );

   // Every tenth millisecond tick in the slow rate
   assign ten_ms = ctrl_q[charge_pkg::CTRL_RATE_BIT];
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slow_cnt_q <= 4'h0;
      end else if (ms_tick) begin
         slow_cnt_q <= (slow_cnt_q == 4'(charge_pkg::SLOW_RATE_MS - 1))
                       ? 4'h0 : slow_cnt_q + 4'h1;
      end
   end

   assign conv_start = ms_tick && (!ten_ms
      || slow_cnt_q == 4'(charge_pkg::SLOW_RATE_MS - 1));

   assign smp.valid = conv_valid;
   assign smp.data = conv_data;
   assign smp.ten_ms = ten_ms;
   // Fresh window on CV entry so the decision sees only CV current
   assign smp.win_clear = state_q != charge_pkg::ST_CV
                          && state_d == charge_pkg::ST_CV;

   current_averager #(.FAST_N(FAST_N), .SLOW_N(SLOW_N)) u_avg (
      .sys_clk(sys_clk),
      .rst(rst),
      .smp(smp)
   );

   //-------------------------------------------------------------------
   // Charge sequencer
   //-------------------------------------------------------------------
   logic eoc_hit;

   // End of charge is judged once per new average
   assign eoc_hit = smp.avg_valid
                    && smp.avg < 12'(end_cur_q);

   // Phase selection, no host action needed to start
   always_comb begin
      state_d = state_q;
      case (state_q)
         charge_pkg::ST_IDLE: begin
            if (bat_mv < charge_pkg::PRE_THR_MV) begin
               state_d = charge_pkg::ST_PRE;
            end else if (bat_mv < cv_mv) begin
               state_d = charge_pkg::ST_CC;
            end else begin
               state_d = charge_pkg::ST_CV;
            end
         end
         charge_pkg::ST_PRE: begin
            if (bat_mv >= charge_pkg::PRE_THR_MV) begin
               state_d = charge_pkg::ST_CC;
            end
         end
         charge_pkg::ST_CC: begin
            if (bat_mv < charge_pkg::PRE_THR_MV) begin
               state_d = charge_pkg::ST_PRE;
            end else if (bat_mv >= cv_mv) begin
               state_d = charge_pkg::ST_CV;
            end
         end
         charge_pkg::ST_CV: begin
            if (eoc_hit) begin
               state_d = charge_pkg::ST_DONE;
            end
         end
         charge_pkg::ST_DONE: begin
            if (on_chg && bat_mv < recharge_mv) begin
               state_d = charge_pkg::ST_IDLE;
            end
         end
         default: state_d = charge_pkg::ST_IDLE;
      endcase
      if (!chg_ok) begin
         state_d = charge_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= charge_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign eoc_set = state_q == charge_pkg::ST_CV
                    && state_d == charge_pkg::ST_DONE;

   // Stage enables decoded from the state flops, codes from the registers
   assign charge_en = state_q == charge_pkg::ST_PRE
                      || state_q == charge_pkg::ST_CC
                      || state_q == charge_pkg::ST_CV;
   assign precharge_active = state_q == charge_pkg::ST_PRE;
   assign cv_active = state_q == charge_pkg::ST_CV;
   assign pre_charge_current =
      cur_cfg_q[charge_pkg::PRE_MSB:charge_pkg::PRE_LSB];
   assign fast_charge_current = cur_cfg_q[charge_pkg::FAST_MSB:0];
   assign charge_target_voltage =
      tgt_cfg_q[charge_pkg::TGT_MSB:charge_pkg::TGT_LSB];

   //-------------------------------------------------------------------
   // Input gates and LED
   //-------------------------------------------------------------------
   logic blink_tick;
   logic led_q;
   logic blink_on;

   // Wall input wins, so both switches never close together
   assign wall_input_gate = wall_ok;
   assign usb_input_gate = usb_ok && !wall_ok;

   tick_divider #(.DIV(BLINK_CYCLES)) u_blink_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(blink_tick)
   );

   // Flash only until the application can come up
   assign blink_on = ctrl_q[charge_pkg::CTRL_BLINK_BIT]
                     && charge_en && !app_pg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         led_q <= 1'b0;
      end else if (!blink_on) begin
         led_q <= 1'b0;
      end else if (blink_tick) begin
         led_q <= !led_q;
      end
   end

   assign led_output_a = led_q && !ctrl_q[charge_pkg::CTRL_LEDSEL_BIT];
   assign led_output_b = led_q && ctrl_q[charge_pkg::CTRL_LEDSEL_BIT];

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   a_pre_entry: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == charge_pkg::ST_IDLE && chg_ok
      && bat_mv < charge_pkg::PRE_THR_MV
      |=> precharge_active && charge_en)
      else $error("low battery did not enter pre-charge");

   a_pre_field: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == charge_pkg::ADDR_CHG_CUR
      |=> pre_charge_current == $past(reg_wdata[7:6])
      && fast_charge_current == $past(reg_wdata[5:0]))
      else $error("charge current fields not updated");

   a_cc_band: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == charge_pkg::ST_PRE && chg_ok
      && bat_mv >= charge_pkg::PRE_THR_MV
      |=> state_q == charge_pkg::ST_CC && !precharge_active)
      else $error("no fast charge above pre-charge level");

   a_cv_entry: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == charge_pkg::ST_CC && chg_ok && bat_mv >= cv_mv
      && bat_mv >= charge_pkg::PRE_THR_MV |=> cv_active)
      else $error("no CV phase near target");

   a_eoc_only_cv: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(state_q == charge_pkg::ST_DONE)
      |-> $past(state_q) == charge_pkg::ST_CV)
      else $error("charge ended outside CV phase");

   a_eoc_decide: assert property (@(posedge sys_clk) disable iff (rst)
      cv_active && chg_ok && eoc_hit
      |=> state_q == charge_pkg::ST_DONE && eoc_flag_q && !charge_en)
      else $error("low average current did not end charge");

   a_recharge: assert property (@(posedge sys_clk) disable iff (rst)
      state_q == charge_pkg::ST_DONE && chg_ok
      && !(on_chg && bat_mv < recharge_mv)
      |=> state_q == charge_pkg::ST_DONE)
      else $error("recharge started above threshold");

   a_idle_off: assert property (@(posedge sys_clk) disable iff (rst)
      !chg_ok |=> state_q == charge_pkg::ST_IDLE ##0 !charge_en)
      else $error("charging without a charger");

   a_gate_excl: assert property (@(posedge sys_clk) disable iff (rst)
      !(wall_input_gate && usb_input_gate)
      && wall_input_gate == $past(wall_supply, 2))
      else $error("input gates wrong");

   a_led_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      !blink_on |=> !led_output_a && !led_output_b)
      else $error("LED lit while blinking is off");
endmodule // liion_charge_phase_controller
`default_nettype wire

// file: charge_pkg.sv
// Constants, register map and state encoding for the charge sequencer
//----------------------------------------------------------------------
// Overview of operation
// - Below 2.9 V charge at pre-charge current
// - Pre-charge current from bits 7:6
// - Pre-charge starts without host action
// - Between 2.9 V and target: constant current
// - Fast-charge current from bits 5:0
// - Near target switch to constant voltage
// - End of charge only in CV phase
// - Complete when average current below threshold
// - Restart below target minus recharge drop
// - Target 3.65 V plus 25 mV steps
// - Recharge drop from bit 6
// - Restart only when system runs from charger
// - Sample current every 1 ms or 10 ms
// - Average current over last 10 seconds
// - Drive wall and USB input gates
// - Blink LED while charging until app powers
//----------------------------------------------------------------------
`default_nettype none
package charge_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned SAMPLE_PERIOD_MS = 1;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
   localparam int unsigned SLOW_RATE_MS = 10;
   localparam int unsigned AVG_WINDOW_S = 10;
   localparam int unsigned AVG_FAST_N = AVG_WINDOW_S * 1000 / 1;
   localparam int unsigned AVG_SLOW_N = AVG_WINDOW_S * 1000 / SLOW_RATE_MS;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
   // Voltage figures in millivolts
   localparam logic [12:0] PRE_THR_MV = 13'h0b54; // 2900 mV
   localparam logic [12:0] VT_BASE_MV = 13'h0e42; // 3650 mV
   localparam logic [12:0] VT_STEP_MV = 13'h0019; // 25 mV
   localparam logic [12:0] CV_MARGIN_MV = 13'h0019; // 25 mV
   localparam logic [12:0] DROP_LO_MV = 13'h0064; // 100 mV
   localparam logic [12:0] DROP_HI_MV = 13'h00c8; // 200 mV
   // Register offsets
   localparam logic [7:0] ADDR_CHG_CUR = 8'h41;
   localparam logic [7:0] ADDR_TGT_V = 8'h42;
   localparam logic [7:0] ADDR_RECHG = 8'h43;
   localparam logic [7:0] ADDR_END_CUR = 8'h59;
   localparam logic [7:0] ADDR_CTRL = 8'h60;
   localparam logic [7:0] ADDR_STATUS = 8'h61;
   // Reset values
   localparam logic [7:0] RST_CHG_CUR = 8'h44;
   localparam logic [7:0] RST_TGT_V = 8'hb0;
   localparam logic [7:0] RST_RECHG = 8'h40;
   localparam logic [7:0] RST_END_CUR = 8'h32;
   localparam logic [7:0] RST_CTRL = 8'h02;
   // Field positions
   localparam int unsigned PRE_MSB = 7;
   localparam int unsigned PRE_LSB = 6;
   localparam int unsigned FAST_MSB = 5;
   localparam int unsigned TGT_MSB = 7;
   localparam int unsigned TGT_LSB = 3;
   localparam int unsigned DROP_BIT = 6;
   localparam int unsigned CTRL_RATE_BIT = 0;
   localparam int unsigned CTRL_BLINK_BIT = 1;
   localparam int unsigned CTRL_LEDSEL_BIT = 2;
   localparam int unsigned STAT_EOC_BIT = 3;
   // Sequencer states, Gray along idle-pre-cc-cv-done
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE = 3'b001,
      ST_CC = 3'b011,
      ST_CV = 3'b010,
      ST_DONE = 3'b110
   } chg_state_e;
endpackage
`default_nettype wire

// file: sample_if.sv
// Current sample stream and averaged result between sequencer and averager
`timescale 1ns/1ps
`default_nettype none
interface sample_if;
   logic valid;
   logic [11:0] data;
   logic ten_ms;
   logic win_clear;
   logic avg_valid;
   logic [11:0] avg;
   modport src (output valid, data, ten_ms, win_clear,
                input avg_valid, avg);
   modport avg_side (input valid, data, ten_ms, win_clear,
                     output avg_valid, avg);
endinterface
`default_nettype wire

// file: tick_divider.sv
// Free-running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 20000
) (
   input wire logic sys_clk, // System clock
   input wire logic rst,     // Async reset, high
   output logic tick         // One-cycle pulse
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] cnt_q;

   // Count up through the period
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   assign tick = (cnt_q == LAST);

   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (rst)
      tick |=> !tick)
      else $error("tick repeated on consecutive cycles");
endmodule // tick_divider
`default_nettype wire

// file: current_averager.sv
// Block average of charge-current samples over a fixed window
`timescale 1ns/1ps
`default_nettype none
module current_averager #(
   parameter int unsigned FAST_N = charge_pkg::AVG_FAST_N,
   parameter int unsigned SLOW_N = charge_pkg::AVG_SLOW_N
) (
   input wire logic sys_clk,      // System clock
   input wire logic rst,          // Async reset, high
   sample_if.avg_side smp         // Samples in, average out
);
   logic [25:0] sum_q;
   logic [13:0] cnt_q;
   logic rate_q;
   logic [25:0] sum_w;
   logic [25:0] quot_w;
   logic last_w;
   logic [11:0] avg_q;
   logic avg_valid_q;

   // Window length follows the sampling rate
   assign last_w = smp.ten_ms ? (cnt_q == 14'(SLOW_N - 1))
                              : (cnt_q == 14'(FAST_N - 1));
   assign sum_w = sum_q + 26'(smp.data);
   assign quot_w = smp.ten_ms ? sum_w / 26'(SLOW_N)
                              : sum_w / 26'(FAST_N);

   // Rate change restarts the window so old samples do not skew it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sum_q <= '0;
         cnt_q <= '0;
         rate_q <= 1'b0;
      end else begin
         rate_q <= smp.ten_ms;
         if (smp.win_clear || rate_q != smp.ten_ms) begin
            sum_q <= '0;
            cnt_q <= '0;
         end else if (smp.valid && last_w) begin
            sum_q <= '0;
            cnt_q <= '0;
         end else if (smp.valid) begin
            sum_q <= sum_w;
            cnt_q <= cnt_q + 14'h0001;
         end
      end
   end

   // Publish one average per full window
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         avg_q <= '0;
         avg_valid_q <= 1'b0;
      end else begin
         avg_valid_q <= smp.valid && last_w && !smp.win_clear
                        && rate_q == smp.ten_ms;
         if (smp.valid && last_w) begin
            avg_q <= quot_w[11:0];
         end
      end
   end

   assign smp.avg = avg_q;
   assign smp.avg_valid = avg_valid_q;
endmodule // current_averager
`default_nettype wire

// file: battery_model.sv
// Behavioural battery cell and charge-current converter
`timescale 1ns/1ps
`default_nettype none
module battery_model (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Async reset, high
   input wire logic conv_start, // Conversion request
   input wire logic [12:0] cell_mv, // Cell voltage to present
   input wire logic [11:0] cell_ma, // Cell current to report
   output logic [12:0] bat_mv, // Voltage seen by device
   output var logic conv_valid, // Result strobe
   output logic [11:0] conv_data // Result, mA
);
   logic [11:0] last_q;
   assign bat_mv = cell_mv;
   // Answer one cycle after a request; lines scrambled off the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         conv_valid <= 1'b0;
         last_q <= 12'h000;
      end else begin
         conv_valid <= conv_start;
         if (conv_start) last_q <= cell_ma;
      end
   end
   assign conv_data = conv_valid ? last_q : ~last_q;
endmodule // battery_model
`default_nettype wire

// file: liion_charge_phase_controller_test.sv
// Register-level testbench of the charge phase sequencer
`timescale 1ns/1ps
`default_nettype none
module liion_charge_phase_controller_test;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
   logic wall_supply = 1'b0, usb_supply = 1'b0;
   logic sys_on_charger = 1'b0, app_power_good = 1'b0;
   logic [12:0] cell_mv = 13'h0af0, bat_mv;
   logic [11:0] cell_ma = 12'h064, conv_data;
   logic conv_start, conv_valid, charge_en, precharge_active, cv_active;
   logic [1:0] pre_charge_current;
   logic [5:0] fast_charge_current;
   logic [4:0] charge_target_voltage;
   logic wall_input_gate, usb_input_gate, led_output_a, led_output_b;
   logic hi, lo;
   int fail_count = 0, n_compared = 0;
   // Short counts keep the averaging window and blink in reach
   liion_charge_phase_controller #(.MS_CYCLES(20), .BLINK_CYCLES(8),
      .FAST_N(4), .SLOW_N(2)) u_liion_charge_phase_controller (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .wall_supply(wall_supply),
      .usb_supply(usb_supply), .sys_on_charger(sys_on_charger),
      .app_power_good(app_power_good), .bat_mv(bat_mv),
      .conv_start(conv_start), .conv_valid(conv_valid),
      .conv_data(conv_data), .charge_en(charge_en),
      .precharge_active(precharge_active), .cv_active(cv_active),
      .pre_charge_current(pre_charge_current),
      .fast_charge_current(fast_charge_current),
      .charge_target_voltage(charge_target_voltage),
      .wall_input_gate(wall_input_gate), .usb_input_gate(usb_input_gate),
      .led_output_a(led_output_a), .led_output_b(led_output_b));
   battery_model u_battery_model (.sys_clk(sys_clk), .rst(rst),
      .conv_start(conv_start), .cell_mv(cell_mv), .cell_ma(cell_ma),
      .bat_mv(bat_mv), .conv_valid(conv_valid), .conv_data(conv_data));
   // 20 MHz clock
   always #25 sys_clk = ~sys_clk;
   //---------------------------------------------------------------
   // Access and compare tasks
   //---------------------------------------------------------------
   task automatic end_sim;
      if (fail_count == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [12:0] e, g);
      n_compared++;
      if (e !== g) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [12:0] e,
                     input logic [7:0] m = 8'hff);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      chk("rdata", e, 13'(d & m));
   endtask
   // State field only; the other status bits follow the pins and the completion flag
   task automatic st(input logic [2:0] e);
      rd(8'h61, 13'(e), 8'h07);
   endtask
   // Spacing of conversion requests, sampled away from the edge
   task automatic period(input logic [12:0] e);
      int n;
      for (n = 0; n < 500; n++) begin
         @(negedge sys_clk);
         if (conv_start === 1'b1) break;
      end
      for (n = 1; n < 500; n++) begin
         @(negedge sys_clk);
         if (conv_start === 1'b1) break;
      end
      chk("period", e, 13'(n));
   endtask
   // Watchdog well beyond the expected run of about 1200 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      end_sim;
   end
   //---------------------------------------------------------------
   // Test sequence
   //---------------------------------------------------------------
   initial begin
      cyc(16);
      rst <= 1'b0;
      rd(charge_pkg::ADDR_CHG_CUR, 13'(charge_pkg::RST_CHG_CUR));
      rd(charge_pkg::ADDR_TGT_V, 13'(charge_pkg::RST_TGT_V));
      rd(charge_pkg::ADDR_RECHG, 13'(charge_pkg::RST_RECHG));
      rd(charge_pkg::ADDR_END_CUR, 13'(charge_pkg::RST_END_CUR));
      rd(8'h10, 13'h0000);
      wr(8'h41, 8'h8a);
      wr(8'h42, 8'hb0);
      #1 chk("pre", 13'h0002, 13'(pre_charge_current));
      chk("fast", 13'h000a, 13'(fast_charge_current));
      chk("tgt", 13'h0016, 13'(charge_target_voltage));
      st(charge_pkg::ST_IDLE);
      // Empty cell on wall power: pre-charge with no host action
      wall_supply <= 1'b1;
      usb_supply <= 1'b1;
      cyc(6);
      #1 chk("pre_act", 13'h0001, 13'(precharge_active));
      chk("wall_g", 13'h0001, 13'(wall_input_gate));
      chk("usb_g", 13'h0000, 13'(usb_input_gate));
      hi = 1'b0;
      lo = 1'b0;
      repeat (40) begin
         @(negedge sys_clk);
         hi |= led_output_a === 1'b1;
         lo |= led_output_a === 1'b0;
      end
      chk("blink", 13'h0001, 13'(hi & lo));
      // Second LED output takes over when selected
      wr(charge_pkg::ADDR_CTRL, 8'h06);
      hi = 1'b0;
      lo = 1'b0;
      repeat (40) begin
         @(negedge sys_clk);
         hi |= led_output_b === 1'b1;
         lo |= led_output_a === 1'b1;
      end
      chk("blink_b", 13'h0002, 13'({hi, lo}));
      app_power_good <= 1'b1;
      cyc(8);
      #1 chk("led", 13'h0000, 13'(led_output_b));
      // Low current in constant current must not end the charge
      cell_mv <= 13'h0bb8;
      cell_ma <= 12'h028;
      cyc(300);
      #1 chk("cc_pre", 13'h0000, 13'(precharge_active));
      st(charge_pkg::ST_CC);
      period(13'd20);
      wr(charge_pkg::ADDR_CTRL, 8'h03);
      period(13'd200);
      wr(charge_pkg::ADDR_CTRL, 8'h02);
      // Near target: constant voltage, then end of charge
      cell_mv <= 13'h1054;
      cell_ma <= 12'h03c;
      cyc(150);
      #1 chk("cv", 13'h0001, 13'(cv_active));
      st(charge_pkg::ST_CV);
      cell_ma <= 12'h028;
      cyc(200);
      st(charge_pkg::ST_DONE);
      rd(8'h61, 13'h003e);
      chk("en_done", 13'h0000, 13'(charge_en));
      wr(charge_pkg::ADDR_STATUS, 8'h08);
      rd(charge_pkg::ADDR_STATUS, 13'h0036);
      // Recharge threshold follows the drop bit and charger supply
      cell_mv <= 13'h0ffa;
      sys_on_charger <= 1'b1;
      cyc(6);
      st(charge_pkg::ST_DONE);
      sys_on_charger <= 1'b0;
      wr(charge_pkg::ADDR_RECHG, 8'h00);
      cyc(6);
      st(charge_pkg::ST_DONE);
      sys_on_charger <= 1'b1;
      cyc(6);
      #1 chk("rechg", 13'h0001, 13'(charge_en));
      wall_supply <= 1'b0;
      cyc(6);
      #1 chk("usb_g", 13'h0001, 13'(usb_input_gate));
      chk("usb_chg", 13'h0001, 13'(charge_en));
      usb_supply <= 1'b0;
      cyc(6);
      #1 chk("no_chg", 13'h0000, 13'(charge_en));
      end_sim;
   end
endmodule // liion_charge_phase_controller_test
`default_nettype wire
